// >>> src/trs_top.v
// triggered reading store: trigger, buffer, recall, analog and talk-only
`timescale 1ns/1ns
`include "trs_defs.vh"
module trs_top #(
    parameter DW = 24,
    parameter DEPTH = 512,
    parameter AW = 9,
    parameter CONV_CYCLES = 16
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire trig_key_n,
    input wire rear_trig_n,
    input wire source_operate,
    input wire signed [DW-1:0] meas_value,
    output reg [15:0] dac_value,
    output reg [DW-1:0] talk_data,
    output reg talk_valid,
    input wire talk_ready,
    output reg trigger_overrun_error,
    output reg no_data,
    output reg store_armed
);
// ==================================================
// bus and control registers
reg [31:0] ctrl_r;
reg [31:0] ctrl_nxt;
reg [31:0] delay_r;
reg [31:0] intvl_r;
reg [9:0] size_r;
reg signed [DW-1:0] relofs_r;
wire wr_en = psel & penable & pwrite;
wire rd_en = psel & penable & ~pwrite;
assign pready = 1'b1;
assign pslverr = 1'b0;
wire single_trigger_mode = ctrl_r[`TRS_CTRL_SINGLE];
wire [1:0] trig_src = ctrl_r[`TRS_CTRL_SRC_HI:`TRS_CTRL_SRC_LO];
wire buffer_reading_source = ctrl_r[`TRS_CTRL_BUFSRC];
wire wr_ctrl = wr_en && paddr == `TRS_CTRL_OFF;
wire arm_p = wr_ctrl && pwdata[`TRS_CTRL_ARM];
wire recall_enter = wr_ctrl && pwdata[`TRS_CTRL_RECALL]
    && !ctrl_r[`TRS_CTRL_RECALL];
wire step_f = wr_ctrl && pwdata[`TRS_CTRL_STEPF];
wire step_b = wr_ctrl && pwdata[`TRS_CTRL_STEPB];
wire clr_ovr = wr_ctrl && pwdata[`TRS_CTRL_CLROVR];
wire wr_recl = wr_en && paddr == `TRS_RECL_OFF;
always @* begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl)
        ctrl_nxt = {25'h000_0000, pwdata[6:0] & 7'b111_0111};
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_r <= `TRS_CTRL_RST;
        delay_r <= `TRS_DELAY_RST;
        intvl_r <= `TRS_INTVL_RST;
        size_r <= `TRS_SIZE_RST;
        relofs_r <= {DW{1'b0}};
    end else if (wr_en) begin
        case (paddr)
            `TRS_CTRL_OFF: ctrl_r <= ctrl_nxt;
            `TRS_DELAY_OFF: delay_r <= pwdata;
            `TRS_INTVL_OFF: if (!single_trigger_mode)
                intvl_r <= pwdata;
            `TRS_SIZE_OFF: size_r <= pwdata[9:0];
            `TRS_RELOFS_OFF: relofs_r <= pwdata[DW-1:0];
            default: ;
        endcase
    end
end
// ==================================================
// trigger synchronisers and edge pulses
reg [1:0] key_s;
reg [1:0] ext_s;
reg [1:0] opr_s;
reg key_d;
reg ext_d;
reg opr_d;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        key_s <= 2'b11;
        ext_s <= 2'b11;
        opr_s <= 2'b00;
        key_d <= 1'b1;
        ext_d <= 1'b1;
        opr_d <= 1'b0;
    end else begin
        key_s <= {key_s[0], trig_key_n};
        ext_s <= {ext_s[0], rear_trig_n};
        opr_s <= {opr_s[0], source_operate};
        key_d <= key_s[1];
        ext_d <= ext_s[1];
        opr_d <= opr_s[1];
    end
end
wire key_p = key_d & ~key_s[1];
wire ext_p = ext_d & ~ext_s[1];
wire opr_p = ~opr_d & opr_s[1];
function src_hit;
    input [1:0] sel;
    input [1:0] want;
    input edge_p;
    begin
        src_hit = edge_p && sel == want;
    end
endfunction
wire trig_p = key_p
    | src_hit(trig_src, `TRS_SRC_EXT, ext_p)
    | src_hit(trig_src, `TRS_SRC_OPR, opr_p);
// ==================================================
// trigger sequencer, one-hot
localparam S_IDLE = 3'b001;
localparam S_DELAY = 3'b010;
localparam S_CONV = 3'b100;
reg [2:0] st_r;
reg [2:0] st_nxt;
reg [31:0] cnt_r;
reg [31:0] cnt_nxt;
reg [31:0] icnt_r;
reg [31:0] icnt_nxt;
reg conv_done;
reg conv_done_nxt;
reg ovr_nxt;
always @* begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    icnt_nxt = icnt_r;
    conv_done_nxt = 1'b0;
    ovr_nxt = trigger_overrun_error;
    if (trig_p && st_r != S_IDLE)
        ovr_nxt = 1'b1;
    else if (clr_ovr)
        ovr_nxt = 1'b0;
    case (st_r)
        S_IDLE: begin
            if (!single_trigger_mode) begin
                if (icnt_r >= intvl_r) begin
                    icnt_nxt = 32'h0000_0000;
                    cnt_nxt = 32'h0000_0000;
                    st_nxt = S_CONV;
                end else
                    icnt_nxt = icnt_r + 32'h0000_0001;
            end else if (trig_p) begin
                cnt_nxt = 32'h0000_0000;
                st_nxt = S_DELAY;
            end
        end
        S_DELAY: begin
            if (cnt_r >= delay_r) begin
                cnt_nxt = 32'h0000_0000;
                st_nxt = S_CONV;
            end else
                cnt_nxt = cnt_r + 32'h0000_0001;
        end
        S_CONV: begin
            if (cnt_r >= CONV_CYCLES - 1) begin
                conv_done_nxt = 1'b1;
                st_nxt = S_IDLE;
            end else
                cnt_nxt = cnt_r + 32'h0000_0001;
        end
        default: st_nxt = S_IDLE;
    endcase
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        st_r <= S_IDLE;
        cnt_r <= 32'h0000_0000;
        icnt_r <= 32'h0000_0000;
        conv_done <= 1'b0;
        trigger_overrun_error <= 1'b0;
    end else begin
        st_r <= st_nxt;
        cnt_r <= cnt_nxt;
        icnt_r <= icnt_nxt;
        conv_done <= conv_done_nxt;
        trigger_overrun_error <= ovr_nxt;
    end
end
// ==================================================
// reading buffer
reg signed [DW-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wptr_r;
reg [AW:0] count_r;
reg signed [DW-1:0] max_r;
reg signed [DW-1:0] min_r;
wire wrap = size_r == 10'h000;
wire full = !wrap && count_r >= {1'b0, size_r[AW-1:0]} + size_r[AW] *
    DEPTH[AW:0];
wire store = conv_done && store_armed && !full;
function [AW-1:0] loc_step;
    input [AW-1:0] l;
    input up;
    begin
        if (up)
            loc_step = l + {{(AW-1){1'b0}}, 1'b1};
        else
            loc_step = l - {{(AW-1){1'b0}}, 1'b1};
    end
endfunction
function [AW:0] cnt_inc;
    input [AW:0] c;
    begin
        cnt_inc = c + {{AW{1'b0}}, 1'b1};
    end
endfunction
always @(posedge pclk) begin
    if (store)
        mem[wptr_r] <= meas_value;
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        wptr_r <= {AW{1'b0}};
        count_r <= {(AW+1){1'b0}};
        max_r <= {DW{1'b0}};
        min_r <= {DW{1'b0}};
        store_armed <= 1'b0;
    end else if (arm_p) begin
        wptr_r <= {AW{1'b0}};
        count_r <= {(AW+1){1'b0}};
        store_armed <= 1'b1;
    end else if (store) begin
        wptr_r <= loc_step(wptr_r, 1'b1);
        if (count_r != DEPTH[AW:0])
            count_r <= cnt_inc(count_r);
        if (count_r == 0 || meas_value > max_r)
            max_r <= meas_value;
        if (count_r == 0 || meas_value < min_r)
            min_r <= meas_value;
        if (!wrap && count_r + 1 >= {1'b0, size_r})
            store_armed <= 1'b0;
    end
end
// ==================================================
// recall
reg [AW-1:0] loc_r;
reg [1:0] view_r;
reg [11:0] digits_r;
wire [AW:0] last_loc = (count_r == 0) ? {(AW+1){1'b0}} :
    count_r - {{AW{1'b0}}, 1'b1};
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        loc_r <= {AW{1'b0}};
        view_r <= `TRS_VIEW_LOC;
        digits_r <= 12'h000;
        no_data <= 1'b0;
    end else if (recall_enter) begin
        loc_r <= {AW{1'b0}};
        view_r <= `TRS_VIEW_LOC;
        no_data <= count_r == 0;
    end else if (step_b) begin
        if (view_r == `TRS_VIEW_LOC && loc_r == 0)
            view_r <= `TRS_VIEW_MAX;
        else if (view_r == `TRS_VIEW_MAX)
            view_r <= `TRS_VIEW_MIN;
        else if (view_r == `TRS_VIEW_LOC)
            loc_r <= loc_step(loc_r, 1'b0);
    end else if (step_f) begin
        if (view_r != `TRS_VIEW_LOC)
            view_r <= `TRS_VIEW_LOC;
        else if ({1'b0, loc_r} < last_loc)
            loc_r <= loc_step(loc_r, 1'b1);
    end else if (wr_recl) begin
        if (pwdata[`TRS_RECL_DIRECT]) begin
            view_r <= `TRS_VIEW_LOC;
            loc_r <= bcd_loc(digits_r);
        end else
            case (pwdata[11:10])
                2'd0: digits_r[3:0] <= pwdata[3:0];
                2'd1: digits_r[7:4] <= pwdata[3:0];
                default: digits_r[11:8] <= pwdata[3:0];
            endcase
    end
    if (store && count_r == 0 && !recall_enter)
        no_data <= 1'b0;
end
// location digits 001..512 shown one-based
function [AW-1:0] bcd_loc;
    input [11:0] d;
    reg [11:0] v;
    begin
        v = d[11:8] * 12'd100 + d[7:4] * 12'd10 + {8'h00, d[3:0]};
        if (v == 0)
            v = 12'd1;
        bcd_loc = loc_step(v[AW-1:0], 1'b0);
    end
endfunction
wire signed [DW-1:0] recall_val = (view_r == `TRS_VIEW_MAX) ? max_r :
    (view_r == `TRS_VIEW_MIN) ? min_r : mem[loc_r];
// ==================================================
// analog output scaling
function [15:0] dac_scale;
    input signed [DW-1:0] r;
    reg signed [DW+17:0] p;
    reg signed [DW+17:0] q;
    begin
        p = r * `TRS_DAC_FULL;
        q = p / `TRS_FULL_COUNTS;
        if (r <= 0)
            dac_scale = 16'h0000;
        else if (r >= `TRS_FULL_COUNTS)
            dac_scale = 16'hffff;
        else
            dac_scale = q[15:0];
    end
endfunction
always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        dac_value <= 16'h0000;
    else if (conv_done)
        dac_value <= dac_scale(meas_value);
end
// ==================================================
// talk-only output
reg [AW:0] dump_r;
reg dumping_r;
reg pend_r;
reg signed [DW-1:0] pend_val;
wire dump_start = wr_ctrl && pwdata[`TRS_CTRL_TALK] && !ctrl_r[`TRS_CTRL_TALK]
    && pwdata[`TRS_CTRL_BUFSRC] && !store_armed && count_r != 0;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        talk_valid <= 1'b0;
        talk_data <= {DW{1'b0}};
        dump_r <= {(AW+1){1'b0}};
        dumping_r <= 1'b0;
        pend_r <= 1'b0;
        pend_val <= {DW{1'b0}};
    end else begin
        if (talk_valid && talk_ready)
            talk_valid <= 1'b0;
        if (dump_start) begin
            dumping_r <= 1'b1;
            dump_r <= {(AW+1){1'b0}};
        end
        if (conv_done && ctrl_r[`TRS_CTRL_TALK] && !dumping_r
            && (!buffer_reading_source || store)) begin
            pend_r <= 1'b1;
            pend_val <= meas_value;
        end else if (pend_r && (!talk_valid || talk_ready)) begin
            pend_r <= 1'b0;
            talk_valid <= 1'b1;
            talk_data <= pend_val;
        end else if (dumping_r && (!talk_valid || talk_ready)) begin
            talk_valid <= 1'b1;
            talk_data <= mem[dump_r[AW-1:0]];
            dump_r <= cnt_inc(dump_r);
            if (dump_r + 1 >= count_r)
                dumping_r <= 1'b0;
        end
    end
end
// ==================================================
// read mux
always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
        case (paddr)
            `TRS_CTRL_OFF: prdata <= ctrl_r;
            `TRS_DELAY_OFF: prdata <= delay_r;
            `TRS_INTVL_OFF: prdata <= intvl_r;
            `TRS_SIZE_OFF: prdata <= {22'h00_0000, size_r};
            `TRS_STAT_OFF: prdata <= {16'h0000, view_r, count_r,
                no_data, store_armed, trigger_overrun_error, st_r == S_IDLE};
            `TRS_RECL_OFF: prdata <= {23'h00_0000, loc_r};
            `TRS_RDATA_OFF: prdata <= {{(32-DW){recall_val[DW-1]}},
                recall_val};
            `TRS_RELOFS_OFF: prdata <= {{(32-DW){relofs_r[DW-1]}}, relofs_r};
            default: prdata <= 32'h0000_0000;
        endcase
end
endmodule // trs_top

// >>> src/trs_defs.vh
// constants for the triggered reading store
// Functional notes
// - one-shot mode: one accepted trigger yields one reading stored to buffer
// - front-panel trigger key accepted whatever source is selected
// - external source: each rear-input pulse yields one stored reading
// - operate source: each entry into operate yields one stored reading
// - interval setting writes are refused while in one-shot mode
// - trigger delay counted from each trigger before acquisition begins
// - trigger during delay is discarded and flags overrun
// - recall works during and after storage
// - entering recall shows location 001
// - stepping back from 001 shows buffer maximum then minimum
// - stepping forward increments location, stopping at last location
// - recall accepts a directly entered location, digit by digit
// - empty buffer on recall entry gives a no-data indication
// - storage continues during recall until full; wrap mode never stops
// - analog value scaled so 200000 counts equals full-scale 2V
// - analog value uses the uncorrected reading, ignoring relative offset
// - talk-only: device talks a reading after every conversion
// - measuring keeps its rate; sending paced by listener acceptance
// - buffer source, talk-only during storage: send each reading as stored
// - buffer source, talk-only after storage: dump all readings back to back
// - 512 reading buffer; size 000 selects wrap-around storage
// - arming storage invalidates all stored readings
// - trigger while a reading is still processed flags overrun
`ifndef TRS_DEFS_VH
`define TRS_DEFS_VH
// ==================================================
// register offsets
`define TRS_CTRL_OFF 12'h000
`define TRS_DELAY_OFF 12'h004
`define TRS_INTVL_OFF 12'h008
`define TRS_SIZE_OFF 12'h00C
`define TRS_STAT_OFF 12'h010
`define TRS_RECL_OFF 12'h014
`define TRS_RDATA_OFF 12'h018
`define TRS_RELOFS_OFF 12'h01C
// ==================================================
// control bits
`define TRS_CTRL_SINGLE 0
`define TRS_CTRL_SRC_LO 1
`define TRS_CTRL_SRC_HI 2
`define TRS_CTRL_ARM 3
`define TRS_CTRL_RECALL 4
`define TRS_CTRL_TALK 5
`define TRS_CTRL_BUFSRC 6
`define TRS_CTRL_CLROVR 7
`define TRS_CTRL_STEPF 8
`define TRS_CTRL_STEPB 9
// recall write: digit select [11:10], digit value [3:0], bit 12 direct entry
`define TRS_RECL_DIRECT 12
// ==================================================
// sources and recall views
`define TRS_SRC_KEY 2'd0
`define TRS_SRC_EXT 2'd1
`define TRS_SRC_OPR 2'd2
`define TRS_VIEW_LOC 2'd0
`define TRS_VIEW_MAX 2'd1
`define TRS_VIEW_MIN 2'd2
// ==================================================
// reset values and scaling
`define TRS_CTRL_RST 32'h0000_0001
`define TRS_DELAY_RST 32'h0000_0000
`define TRS_INTVL_RST 32'h0000_0000
`define TRS_SIZE_RST 10'h000
`define TRS_FULL_COUNTS 200000
`define TRS_DAC_FULL 65535
`endif

// >>> tb/trs_monitor.sv
// port checker for the triggered reading store
`timescale 1ns/1ns
`include "trs_defs.vh"
module trs_monitor #(
    parameter DW = 24
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire trig_key_n,
    input wire rear_trig_n,
    input wire source_operate,
    input wire [15:0] dac_value,
    input wire [DW-1:0] talk_data,
    input wire talk_valid,
    input wire talk_ready,
    input wire trigger_overrun_error,
    input wire no_data,
    input wire store_armed
);
    wire ctrl_wr = psel && penable && pwrite && paddr == `TRS_CTRL_OFF;
    wire stat_rd = psel && penable && !pwrite && paddr == `TRS_STAT_OFF;
    reg [3:0] quiet_r;
    // ==================================================
    // cycles since any trigger pin moved
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            quiet_r <= 4'hf;
        else if ($changed({trig_key_n, rear_trig_n, source_operate}))
            quiet_r <= 4'h0;
        else if (quiet_r != 4'hf)
            quiet_r <= quiet_r + 4'h1;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_talk_hold;
        talk_valid && !talk_ready |=> talk_valid;
    endproperty
    a_talk_hold: assert property (p_talk_hold)
        else $error("talk word dropped before accept");
    property p_talk_stable;
        talk_valid && !talk_ready |=> $stable(talk_data);
    endproperty
    a_talk_stable: assert property (p_talk_stable)
        else $error("talk word changed before accept");
    property p_ovr_sticky;
        trigger_overrun_error && !(ctrl_wr && pwdata[7])
            |=> trigger_overrun_error;
    endproperty
    a_ovr_sticky: assert property (p_ovr_sticky)
        else $error("overrun flag lost without clear");
    property p_ovr_cause;
        $rose(trigger_overrun_error) |-> quiet_r < 4'ha;
    endproperty
    a_ovr_cause: assert property (p_ovr_cause)
        else $error("overrun without a trigger edge");
    property p_arm_cause;
        $rose(store_armed) |-> $past(ctrl_wr && pwdata[3]);
    endproperty
    a_arm_cause: assert property (p_arm_cause)
        else $error("storage armed without arm write");
    property p_nodata_cause;
        $rose(no_data) |-> $past(ctrl_wr && pwdata[4]);
    endproperty
    a_nodata_cause: assert property (p_nodata_cause)
        else $error("no data flag outside recall entry");
    property p_stat_read;
        stat_rd |-> prdata[3:1] ==
            $past({no_data, store_armed, trigger_overrun_error});
    endproperty
    a_stat_read: assert property (p_stat_read)
        else $error("status read disagrees with flags");
    property p_reset_idle;
        $rose(presetn) |-> !talk_valid && !trigger_overrun_error &&
            !store_armed && !no_data && dac_value == 16'h0000;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("outputs not idle after reset");
endmodule // trs_monitor
bind trs_top trs_monitor #(.DW(DW)) i_trs_monitor (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .trig_key_n(trig_key_n), .rear_trig_n(rear_trig_n),
    .source_operate(source_operate), .dac_value(dac_value),
    .talk_data(talk_data), .talk_valid(talk_valid), .talk_ready(talk_ready),
    .trigger_overrun_error(trigger_overrun_error), .no_data(no_data),
    .store_armed(store_armed));

// >>> tb/trs_listener.sv
// listen-only bus partner that accepts talked readings
`timescale 1ns/1ns
module trs_listener #(
    parameter DW = 24
) (
    input wire pclk,
    input wire presetn,
    input wire slow,
    input wire talk_valid,
    input wire [DW-1:0] talk_data,
    output reg talk_ready
);
    logic [DW-1:0] got[$];
    reg [2:0] pace_r;
    // accepts only, never commands the talker
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pace_r <= 3'h0;
            talk_ready <= 1'b0;
        end else begin
            pace_r <= pace_r + 3'h1;
            talk_ready <= !slow || pace_r == 3'h7;
            if (talk_valid && talk_ready)
                got.push_back(talk_data);
        end
    end
endmodule // trs_listener

// >>> tb/tb.sv
// self-checking bench for the triggered reading store
`timescale 1ns/1ns
`include "trs_defs.vh"
module tb;
    localparam int CONV = 16;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, rd, lfsr_r = 32'he0a0_bcdd;
    logic trig_key_n = 1, rear_trig_n = 1, source_operate = 0, slow = 0;
    logic [23:0] meas_value = 24'h00_0000, x;
    logic [23:0] v[3];
    wire [31:0] prdata;
    wire [15:0] dac_value;
    wire [23:0] talk_data;
    wire pready, pslverr, talk_valid, talk_ready, trigger_overrun_error;
    wire no_data, store_armed;
    int error_cnt = 0, total_checks = 0, cyc = 0, i, k;
    always #25 pclk = ~pclk;
    trs_top #(.CONV_CYCLES(CONV)) i_trs_top (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trig_key_n(trig_key_n), .rear_trig_n(rear_trig_n),
        .source_operate(source_operate), .meas_value(meas_value),
        .dac_value(dac_value), .talk_data(talk_data), .talk_valid(talk_valid),
        .talk_ready(talk_ready), .trigger_overrun_error(trigger_overrun_error),
        .no_data(no_data), .store_armed(store_armed));
    trs_listener i_trs_listener (.pclk(pclk), .presetn(presetn), .slow(slow),
        .talk_valid(talk_valid), .talk_data(talk_data),
        .talk_ready(talk_ready));
    function automatic logic [23:0] rnd();
        lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
        return 24'(lfsr_r % 200000);
    endfunction
    function automatic logic [15:0] dac_exp(input logic [23:0] r);
        return 16'((64'(r) * `TRS_DAC_FULL) / `TRS_FULL_COUNTS);
    endfunction
    function automatic logic [23:0] pick(input bit hi);
        logic [23:0] b = v[0];
        foreach (v[j]) if (hi ? v[j] > b : v[j] < b) b = v[j];
        return b;
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel <= 0;
        penable <= 0;
    endtask
    task fire(input int s);
        @(posedge pclk);
        trig_key_n <= s != 0;
        rear_trig_n <= s != 1;
        source_operate <= s == 2;
        repeat (4) @(posedge pclk);
        trig_key_n <= 1;
        rear_trig_n <= 1;
        source_operate <= 0;
    endtask
    task settle(input int d);
        repeat (d + CONV + 8) @(posedge pclk);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            $display("unexpected at %0t: run too long", $time);
            final_report;
        end
    end
    // ==================================================
    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        apb(0, `TRS_CTRL_OFF, '0);
        chk(rd, `TRS_CTRL_RST);
        apb(1, `TRS_INTVL_OFF, 32'h0000_0055);
        apb(0, `TRS_INTVL_OFF, '0);
        chk(rd, `TRS_INTVL_RST);
        apb(1, `TRS_CTRL_OFF, 32'h0000_0011);
        apb(0, `TRS_STAT_OFF, '0);
        chk(rd[3], 1'b1);
        $display("test reset and empty recall done");
        apb(1, `TRS_RELOFS_OFF, 32'h0000_4000);
        for (i = 0; i < 3; i++) begin
            x = rnd();
            meas_value <= x;
            apb(1, `TRS_CTRL_OFF, 32'h0000_0009 | (i << 1));
            fire(i);
            settle(0);
            fire(0);
            settle(0);
            apb(0, `TRS_STAT_OFF, '0);
            chk(rd[13:4], 10'h002);
            chk(dac_value, dac_exp(x));
        end
        $display("test trigger sources done");
        for (k = 0; k < 2; k++) begin
            apb(1, `TRS_DELAY_OFF, 32'(20 - 20 * k));
            apb(1, `TRS_CTRL_OFF, 32'h0000_0009);
            fire(0);
            fire(0);
            apb(0, `TRS_STAT_OFF, '0);
            chk(rd[13:4], 10'h000);
            settle(20);
            apb(0, `TRS_STAT_OFF, '0);
            chk(rd[13:4], 10'h001);
            chk(rd[1], 1'b1);
            apb(1, `TRS_CTRL_OFF, 32'h0000_0081);
            apb(0, `TRS_STAT_OFF, '0);
            chk(rd[1], 1'b0);
        end
        $display("test delay and overrun done");
        apb(1, `TRS_DELAY_OFF, '0);
        apb(1, `TRS_SIZE_OFF, 32'h0000_0003);
        apb(1, `TRS_CTRL_OFF, 32'h0000_0009);
        foreach (v[j]) begin
            v[j] = rnd();
            meas_value <= v[j];
            fire(0);
            settle(0);
        end
        apb(1, `TRS_CTRL_OFF, 32'h0000_0011);
        apb(0, `TRS_RDATA_OFF, '0);
        chk(rd[23:0], v[0]);
        chk({pready, pslverr}, 2'b10);
        for (k = 0; k < 2; k++) begin
            apb(1, `TRS_CTRL_OFF, 32'h0000_0211);
            apb(0, `TRS_RDATA_OFF, '0);
            chk(rd[23:0], pick(k == 0));
        end
        for (k = 0; k < 4; k++) begin
            apb(1, `TRS_CTRL_OFF, 32'h0000_0111);
            apb(0, `TRS_RDATA_OFF, '0);
            chk(rd[23:0], v[k < 3 ? k : 2]);
        end
        apb(1, `TRS_RECL_OFF, 32'h0000_0002);
        apb(1, `TRS_RECL_OFF, 32'h0000_1000);
        apb(0, `TRS_RDATA_OFF, '0);
        chk(rd[23:0], v[1]);
        $display("test recall done");
        slow <= 1;
        apb(1, `TRS_CTRL_OFF, 32'h0000_0061);
        for (k = 0; k < 400 && i_trs_listener.got.size() < 3; k++)
            @(posedge pclk);
        foreach (v[j]) chk(i_trs_listener.got[j], v[j]);
        apb(1, `TRS_CTRL_OFF, 32'h0000_0021);
        x = rnd();
        meas_value <= x;
        fire(0);
        settle(0);
        for (k = 0; k < 400 && i_trs_listener.got.size() < 4; k++)
            @(posedge pclk);
        chk(i_trs_listener.got[3], x);
        apb(1, `TRS_CTRL_OFF, 32'h0000_0069);
        x = rnd();
        meas_value <= x;
        fire(0);
        settle(0);
        for (k = 0; k < 400 && i_trs_listener.got.size() < 5; k++)
            @(posedge pclk);
        chk(i_trs_listener.got[4], x);
        $display("test talk-only done");
        final_report;
    end
endmodule // tb
